// *** hdl/ossw_pkg.sv ***
// Package: register map, field positions, reset values and timing for the output safe-state watchdog
package ossw_pkg;
  localparam int          OSSW_LINES       = 32;
  localparam int          OSSW_AW          = 8;
  // Register byte offsets
  localparam logic [7:0]  OSSW_OUT_OFS     = 8'h00;
  localparam logic [7:0]  OSSW_PUP_OFS     = 8'h04;
  localparam logic [7:0]  OSSW_SAFE_OFS    = 8'h08;
  localparam logic [7:0]  OSSW_CTRL_OFS    = 8'h0C;
  localparam logic [7:0]  OSSW_LIMIT_OFS   = 8'h10;
  localparam logic [7:0]  OSSW_KICK_OFS    = 8'h14;
  localparam logic [7:0]  OSSW_STAT_OFS    = 8'h18;
  localparam logic [7:0]  OSSW_IRQ_OFS     = 8'h1C;
  localparam logic [7:0]  OSSW_MASK_OFS    = 8'h20;
  localparam logic [7:0]  OSSW_CMD_OFS     = 8'h24;
  localparam logic [31:0] OSSW_KICK_KEY    = 32'h0000A5A5;
  // Control bits
  localparam int          OSSW_CTRL_ARM    = 0;
  // Command bits
  localparam int          OSSW_CMD_SAVE    = 0;
  localparam int          OSSW_CMD_RESET   = 1;
  // Status bits
  localparam int          OSSW_ST_TRIP     = 0;
  localparam int          OSSW_ST_ARMED    = 1;
  localparam int          OSSW_ST_HOSTOWN  = 2;
  localparam int          OSSW_ST_NVBUSY   = 3;
  localparam int          OSSW_ST_LOADED   = 4;
  // Interrupt bits
  localparam int          OSSW_IRQ_N       = 2;
  localparam int          OSSW_IRQ_TRIP    = 0;
  localparam int          OSSW_IRQ_SAVED   = 1;
  // Reset values
  localparam logic [31:0] OSSW_LIMIT_RST   = 32'h000F4240;
  localparam logic [31:0] OSSW_ZERO32      = 32'h00000000;
  // Non-volatile store write time
  localparam int          OSSW_NV_WR_US    = 5;
  localparam int          OSSW_CLK_MHZ     = 100;
  localparam int          OSSW_NV_WR_CYC   = OSSW_NV_WR_US * OSSW_CLK_MHZ;
  localparam int          OSSW_NV_CW       = 10;
  typedef enum logic [1:0] {OSSW_PWR_LOAD, OSSW_PWR_HOLD, OSSW_RUN, OSSW_TRIP} ossw_mode_type;
endpackage

// *** hdl/ossw_top.sv ***
// Output safe-state watchdog: power-up levels, watchdog timer, APB registers
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ossw_top (
  // Clock and reset
  input  wire  logic                           mclk,
  input  wire  logic                           srst,
  // Host restart seen on the bus side
  input  wire  logic                           host_rst,
  // APB slave
  input  wire  logic                           psel,
  input  wire  logic                           penable,
  input  wire  logic                           pwrite,
  input  wire  logic [ossw_pkg::OSSW_AW-1:0]   paddr,
  input  wire  logic [31:0]                    pwdata,
  input  wire  logic [3:0]                     pstrb,
  output var   logic [31:0]                    prdata,
  output var   logic                           pready,
  output var   logic                           pslverr,
  // Non-volatile power-up level store
  input  wire  logic [ossw_pkg::OSSW_LINES-1:0] nv_rdata,
  output var   logic [ossw_pkg::OSSW_LINES-1:0] nv_wdata,
  output var   logic                           nv_we,
  // Output lines and interrupt
  output var   logic [ossw_pkg::OSSW_LINES-1:0] dout,
  output var   logic                           irq
);
  import ossw_pkg::*;

  localparam logic [OSSW_NV_CW-1:0] NV_LAST = OSSW_NV_CW'(OSSW_NV_WR_CYC - 1);

  ossw_mode_type                  mode_reg;
  ossw_mode_type                  mode_next;
  logic [OSSW_LINES-1:0]          out_reg;
  logic [OSSW_LINES-1:0]          pup_reg;
  logic [OSSW_LINES-1:0]          safe_reg;
  logic                           arm_reg;
  logic [31:0]                    limit_reg;
  logic [31:0]                    cnt_reg;
  logic [OSSW_IRQ_N-1:0]          irq_st_reg;
  logic [OSSW_IRQ_N-1:0]          irq_mask_reg;
  logic [OSSW_NV_CW-1:0]          nv_cnt_reg;
  logic                           nv_busy_reg;
  logic                           loaded_reg;
  logic                           host_rst_s1_reg;
  logic                           host_rst_s2_reg;
  logic [31:0]                    rdata_next;

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] ossw_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Bus decode
  // Access lands only at the edge where pready is sampled high
  wire        acc       = psel && penable && pready;
  wire        wr        = acc && pwrite;
  wire        hit_out   = (paddr == OSSW_OUT_OFS);
  wire        hit_pup   = (paddr == OSSW_PUP_OFS);
  wire        hit_safe  = (paddr == OSSW_SAFE_OFS);
  wire        hit_ctrl  = (paddr == OSSW_CTRL_OFS);
  wire        hit_limit = (paddr == OSSW_LIMIT_OFS);
  wire        hit_kick  = (paddr == OSSW_KICK_OFS);
  wire        hit_stat  = (paddr == OSSW_STAT_OFS);
  wire        hit_irq   = (paddr == OSSW_IRQ_OFS);
  wire        hit_mask  = (paddr == OSSW_MASK_OFS);
  wire        hit_cmd   = (paddr == OSSW_CMD_OFS);
  wire        mapped    = hit_out | hit_pup | hit_safe | hit_ctrl | hit_limit | hit_kick |
                          hit_stat | hit_irq | hit_mask | hit_cmd;
  wire        wr_out    = wr && hit_out;
  wire [31:0] out_new   = ossw_merge(out_reg, pwdata, pstrb);
  wire        wr_ctrl   = wr && hit_ctrl;
  wire [31:0] ctrl_new  = ossw_merge({31'h00000000, arm_reg}, pwdata, pstrb);
  wire        kick      = wr && hit_kick && (pwdata == OSSW_KICK_KEY);
  wire        save_cmd  = wr && hit_cmd && pstrb[0] && pwdata[OSSW_CMD_SAVE] && !nv_busy_reg;
  wire        soft_rst  = wr && hit_cmd && pstrb[0] && pwdata[OSSW_CMD_RESET];
  wire        dev_rst   = srst || soft_rst || host_rst_s2_reg;
  wire        expire    = arm_reg && (mode_reg == OSSW_RUN) && (cnt_reg >= limit_reg);

  // Host restart is asynchronous to mclk
  always_ff @(posedge mclk) begin
    host_rst_s1_reg <= host_rst;
    host_rst_s2_reg <= host_rst_s1_reg;
  end

  // Output mode sequencing
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      OSSW_PWR_LOAD: mode_next = OSSW_PWR_HOLD;
      OSSW_PWR_HOLD: begin
        if (wr_out) begin
          mode_next = OSSW_RUN;
        end
      end
      OSSW_RUN: begin
        if (expire) begin
          mode_next = OSSW_TRIP;
        end
      end
      OSSW_TRIP: begin
        if (wr_out && !arm_reg) begin
          mode_next = OSSW_RUN;
        end
      end
      default: mode_next = OSSW_PWR_LOAD;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      mode_reg <= OSSW_PWR_LOAD;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Driven levels: power-up level until software takes over, safe level once tripped
  always_ff @(posedge mclk) begin
    if (srst) begin
      dout <= nv_rdata;
    end else if (dev_rst || mode_reg == OSSW_PWR_LOAD) begin
      dout <= nv_rdata;
    end else if (mode_next == OSSW_TRIP) begin
      dout <= safe_reg;
    end else if (mode_next == OSSW_RUN) begin
      // Written word goes straight out, so no stale level shows at takeover
      dout <= wr_out ? out_new : out_reg;
    end
  end

  // Stored power-up levels are read on load
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      loaded_reg <= 1'b0;
    end else if (mode_reg == OSSW_PWR_LOAD) begin
      pup_reg    <= nv_rdata;
      loaded_reg <= 1'b1;
    end else if (wr && hit_pup) begin
      pup_reg    <= ossw_merge(pup_reg, pwdata, pstrb);
    end
  end

  // Software output, safe and limit registers
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      out_reg   <= OSSW_ZERO32;
      safe_reg  <= OSSW_ZERO32;
      limit_reg <= OSSW_LIMIT_RST;
    end else begin
      if (wr_out && (mode_reg != OSSW_TRIP || !arm_reg)) begin
        out_reg <= out_new;
      end
      if (wr && hit_safe) begin
        safe_reg <= ossw_merge(safe_reg, pwdata, pstrb);
      end
      if (wr && hit_limit) begin
        limit_reg <= ossw_merge(limit_reg, pwdata, pstrb);
      end
    end
  end

  // Arm bit and timeout counter; kick or arming restarts the count
  always_ff @(posedge mclk) begin
    if (dev_rst) begin
      arm_reg <= 1'b0;
      cnt_reg <= OSSW_ZERO32;
    end else begin
      if (wr_ctrl) begin
        arm_reg <= ctrl_new[OSSW_CTRL_ARM];
      end
      if (kick || wr_ctrl || !arm_reg || mode_reg != OSSW_RUN) begin
        cnt_reg <= OSSW_ZERO32;
      end else if (!expire) begin
        cnt_reg <= cnt_reg + 32'h00000001;
      end
    end
  end

  // Non-volatile store write sequence
  always_ff @(posedge mclk) begin
    if (srst) begin
      nv_busy_reg <= 1'b0;
      nv_we       <= 1'b0;
      nv_wdata    <= OSSW_ZERO32;
      nv_cnt_reg  <= '0;
    end else if (save_cmd) begin
      nv_busy_reg <= 1'b1;
      nv_we       <= 1'b1;
      nv_wdata    <= pup_reg;
      nv_cnt_reg  <= '0;
    end else if (nv_busy_reg) begin
      nv_we <= 1'b0;
      if (nv_cnt_reg == NV_LAST) begin
        nv_busy_reg <= 1'b0;
      end else begin
        nv_cnt_reg <= nv_cnt_reg + 1'b1;
      end
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  wire [OSSW_IRQ_N-1:0] irq_set = {nv_busy_reg && nv_cnt_reg == NV_LAST, expire};
  wire [OSSW_IRQ_N-1:0] irq_clr = (wr && hit_irq && pstrb[0]) ? pwdata[OSSW_IRQ_N-1:0] : '0;

  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_st_reg   <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~irq_clr) | irq_set;
      if (wr && hit_mask && pstrb[0]) begin
        irq_mask_reg <= pwdata[OSSW_IRQ_N-1:0];
      end
      irq <= |(((irq_st_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // Read mux
  always_comb begin
    rdata_next = OSSW_ZERO32;
    if (hit_out) begin
      rdata_next = out_reg;
    end else if (hit_pup) begin
      rdata_next = pup_reg;
    end else if (hit_safe) begin
      rdata_next = safe_reg;
    end else if (hit_ctrl) begin
      rdata_next = {31'h00000000, arm_reg};
    end else if (hit_limit) begin
      rdata_next = limit_reg;
    end else if (hit_kick) begin
      rdata_next = cnt_reg;
    end else if (hit_stat) begin
      rdata_next[OSSW_ST_TRIP]    = (mode_reg == OSSW_TRIP);
      rdata_next[OSSW_ST_ARMED]   = arm_reg;
      rdata_next[OSSW_ST_HOSTOWN] = (mode_reg == OSSW_RUN);
      rdata_next[OSSW_ST_NVBUSY]  = nv_busy_reg;
      rdata_next[OSSW_ST_LOADED]  = loaded_reg;
    end else if (hit_irq) begin
      rdata_next[OSSW_IRQ_N-1:0] = irq_st_reg;
    end else if (hit_mask) begin
      rdata_next[OSSW_IRQ_N-1:0] = irq_mask_reg;
    end
  end

  // APB answer: no wait state, access phase ends at its first cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= OSSW_ZERO32;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rdata_next : OSSW_ZERO32;
    end
  end

  // Assertions
  property p_trip_safe;
    @(posedge mclk) disable iff (dev_rst)
    (mode_reg == OSSW_RUN && expire && !dev_rst) |=> (dout == safe_reg) && (mode_reg == OSSW_TRIP);
  endproperty
  a_trip_safe: assert property (p_trip_safe) else $error("safe levels not driven after expiry");

  property p_trip_hold;
    @(posedge mclk) disable iff (dev_rst)
    (mode_reg == OSSW_TRIP && arm_reg && !dev_rst) |=> (mode_reg == OSSW_TRIP) && (dout == safe_reg);
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("tripped state left while armed");

  property p_reset_release;
    @(posedge mclk) (soft_rst && !srst) |=> (mode_reg == OSSW_PWR_LOAD) && !arm_reg;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset did not release watchdog");

  property p_pup_hold;
    @(posedge mclk) disable iff (srst)
    (mode_reg == OSSW_PWR_HOLD && !wr_out && !dev_rst) |=> (dout == $past(dout));
  endproperty
  a_pup_hold: assert property (p_pup_hold) else $error("power-up levels changed without host write");

  property p_load_nv;
    @(posedge mclk) disable iff (srst)
    (mode_reg == OSSW_PWR_LOAD && !dev_rst) |=> (pup_reg == $past(nv_rdata)) && (mode_reg == OSSW_PWR_HOLD);
  endproperty
  a_load_nv: assert property (p_load_nv) else $error("stored levels not loaded");

  property p_nv_write;
    @(posedge mclk) disable iff (srst)
    save_cmd |=> nv_we && (nv_wdata == $past(pup_reg)) ##1 !nv_we;
  endproperty
  a_nv_write: assert property (p_nv_write) else $error("store write pulse wrong");

  property p_pup_write;
    @(posedge mclk) disable iff (dev_rst)
    (wr && hit_pup && pstrb == 4'hF && mode_reg != OSSW_PWR_LOAD) |=> (pup_reg == $past(pwdata));
  endproperty
  a_pup_write: assert property (p_pup_write) else $error("power-up level write lost");

  property p_glitch_free;
    @(posedge mclk) disable iff (srst)
    (mode_reg == OSSW_PWR_LOAD && !dev_rst) |=> (dout == $past(nv_rdata));
  endproperty
  a_glitch_free: assert property (p_glitch_free) else $error("output not at power-up level");

  property p_kick;
    @(posedge mclk) disable iff (dev_rst)
    (kick && mode_reg == OSSW_RUN) |=> (cnt_reg == 32'h00000000);
  endproperty
  a_kick: assert property (p_kick) else $error("refresh did not restart count");
endmodule
`default_nettype wire

// *** sim/ossw_nv_model.sv ***
// Non-volatile power-up level store seen from the card logic
`timescale 1ns/1ps
`default_nettype none
module ossw_nv_model #(
  parameter logic [31:0] INIT = 32'h00000000
) (
  // Clock
  input  wire logic        mclk,
  // Store write port
  input  wire logic        nv_we,
  input  wire logic [31:0] nv_wdata,
  // Stored levels
  output var  logic [31:0] nv_rdata
);
  logic [31:0] store_reg = INIT;
  // No reset: contents outlive every device reset
  always_ff @(posedge mclk) begin
    if (nv_we) begin
      store_reg <= nv_wdata;
    end
  end
  assign nv_rdata = store_reg;
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the output safe-state watchdog
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ossw_pkg::*;
  localparam logic [31:0] PUP0 = 32'hA5C30F1E;
  localparam logic [31:0] PUP1 = 32'h12345678;
  localparam logic [31:0] SAFE = 32'h0F0F0F0F;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ossw_row_type;
  logic         mclk, srst, host_rst, psel, penable, pwrite, nv_we, pready, pslverr, irq, err;
  logic [3:0]   pstrb;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, nv_rdata, nv_wdata, dout, rd;
  int           errors, checked, cyc, n;
  ossw_row_type rows [8] = '{
    '{1'b0, OSSW_LIMIT_OFS, 32'h00000000, OSSW_LIMIT_RST, 1'b0},
    '{1'b0, OSSW_SAFE_OFS, 32'h00000000, 32'h00000000, 1'b0},
    '{1'b0, OSSW_CTRL_OFS, 32'h00000000, 32'h00000000, 1'b0},
    '{1'b1, OSSW_PUP_OFS, PUP1, PUP1, 1'b0},
    '{1'b1, OSSW_LIMIT_OFS, 32'h00000014, 32'h00000014, 1'b0},
    '{1'b1, OSSW_MASK_OFS, 32'h00000003, 32'h00000003, 1'b0},
    '{1'b1, OSSW_CMD_OFS, 32'h00000000, 32'h00000000, 1'b0},
    '{1'b1, 8'h40, 32'hFFFFFFFF, 32'h00000000, 1'b1}};

  ossw_top dut (.mclk(mclk), .srst(srst), .host_rst(host_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nv_rdata(nv_rdata), .nv_wdata(nv_wdata), .nv_we(nv_we), .dout(dout), .irq(irq));
  ossw_nv_model #(.INIT(PUP0)) nv (.mclk(mclk), .nv_we(nv_we), .nv_wdata(nv_wdata), .nv_rdata(nv_rdata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task end_of_test;
    if (errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; read data and error land in rd and err
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task do_rst(input logic [31:0] p);
    @(posedge mclk);
    srst <= 1'b1;
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    repeat (6) begin
      @(negedge mclk);
      chk(dout, p);
    end
  endtask

  // Runs the host into a trip with one refresh on the way
  task trip(input logic [31:0] o);
    apb(1'b1, OSSW_LIMIT_OFS, 32'h00000014);
    apb(1'b1, OSSW_SAFE_OFS, SAFE);
    apb(1'b1, OSSW_OUT_OFS, o);
    @(negedge mclk);
    chk(dout, o);
    apb(1'b1, OSSW_CTRL_OFS, 32'h00000001);
    repeat (10) @(negedge mclk);
    apb(1'b1, OSSW_KICK_OFS, OSSW_KICK_KEY);
    repeat (15) @(negedge mclk);
    chk(dout, o);
    repeat (30) @(negedge mclk);
    chk(dout, SAFE);
  endtask

  initial begin
    srst = 1'b1;
    host_rst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    errors = 0;
    checked = 0;
    cyc = 0;
    do_rst(PUP0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        apb(1'b1, rows[i].a, rows[i].d);
        chk({31'h0, err}, {31'h0, rows[i].e});
      end
      apb(1'b0, rows[i].a, 32'h00000000);
      chk(rd, rows[i].x);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    @(negedge mclk);
    chk(dout, PUP0);
    apb(1'b1, OSSW_CMD_OFS, 32'h00000001);
    n = 0;
    do begin
      apb(1'b0, OSSW_STAT_OFS, 32'h00000000);
      n++;
    end while (rd[OSSW_ST_NVBUSY] !== 1'b0 && n < 400);
    chk({31'h0, rd[OSSW_ST_NVBUSY]}, 32'h00000000);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b0, OSSW_IRQ_OFS, 32'h00000000);
    chk(rd, 32'h00000002);
    apb(1'b1, OSSW_IRQ_OFS, 32'h00000002);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h00000000);
    do_rst(PUP1);
    apb(1'b1, OSSW_MASK_OFS, 32'h00000000);
    trip(32'hFFFF0000);
    chk({31'h0, irq}, 32'h00000000);
    apb(1'b1, OSSW_OUT_OFS, 32'h11111111);
    @(negedge mclk);
    chk(dout, SAFE);
    apb(1'b0, OSSW_STAT_OFS, 32'h00000000);
    chk({31'h0, rd[OSSW_ST_TRIP]}, 32'h00000001);
    apb(1'b1, OSSW_MASK_OFS, 32'h00000001);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h00000001);
    apb(1'b1, OSSW_IRQ_OFS, 32'h00000001);
    repeat (2) @(negedge mclk);
    chk({31'h0, irq}, 32'h00000000);
    apb(1'b1, OSSW_CTRL_OFS, 32'h00000000);
    apb(1'b1, OSSW_OUT_OFS, 32'h22222222);
    @(negedge mclk);
    chk(dout, 32'h22222222);
    trip(32'h33333333);
    apb(1'b1, OSSW_CMD_OFS, 32'h00000002);
    repeat (4) @(negedge mclk);
    chk(dout, PUP1);
    trip(32'h44444444);
    @(posedge mclk);
    host_rst <= 1'b1;
    repeat (4) @(posedge mclk);
    host_rst <= 1'b0;
    repeat (6) @(negedge mclk);
    chk(dout, PUP1);
    end_of_test();
  end
endmodule
`default_nettype wire
